// ==== mxaf_addr_filter.v ====
// extra station address entries with ahb-lite registers and frame match
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "mxaf_map.vh"
module mxaf_addr_filter (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire frame_valid,
    input wire [47:0] frame_dst,
    input wire [47:0] frame_src,
    output reg filter_hit_valid,
    output reg filter_hit,
    output reg [1:0] entry_hit
);
    // programmed entries (index 0 = third address, 1 = fourth)
    reg [7:0] ctl_q [0:1];
    reg [15:0] hi_q [0:1];
    reg [31:0] lo_q [0:1];
    // copies seen by the receive filter
    reg [7:0] act_ctl_q [0:1];
    reg [15:0] act_hi_q [0:1];
    reg [31:0] act_lo_q [0:1];
    reg [1:0] cfg_q;
    reg [1:0] sync_pend_q;
    // ahb data-phase state
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] wr_ofs_q;
    reg [3:0] wr_be_q;
    reg [7:0] rd_ofs_q;
    wire [1:0] raw_hit;
    wire take;
    wire [31:0] e2_high_new;
    wire [31:0] e3_high_new;
    integer k;

    // byte enables of a transfer from its size and low address
    function [3:0] lane_en;
        input [2:0] size;
        input [1:0] a;
        begin
            case (size)
                `MXAF_HSIZE_BYTE: lane_en = 4'h1 << a;
                `MXAF_HSIZE_HALF: lane_en = a[1] ? 4'hC : 4'h3;
                default: lane_en = 4'hF;
            endcase
        end
    endfunction

    // merge written lanes into an old word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // pack entry control and upper address into the high word
    function [31:0] high_word;
        input [7:0] c;
        input [15:0] h;
        begin
            high_word = {c, 8'h00, h};
        end
    endfunction

    assign take = hsel & hready & (htrans == `MXAF_HTRANS_NONSEQ ||
        htrans == `MXAF_HTRANS_SEQ);

    // high words after merging the written lanes; 23:16 are dropped
    assign e2_high_new = merge(high_word(ctl_q[0], hi_q[0]), hwdata, wr_be_q);
    assign e3_high_new = merge(high_word(ctl_q[1], hi_q[1]), hwdata, wr_be_q);

    // ahb handshake: writes zero-wait, reads one wait state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            wr_be_q <= 4'h0;
            rd_ofs_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hresp <= 1'b0;
            wr_pend_q <= take & hwrite;
            rd_pend_q <= 1'b0;
            if (take) begin
                wr_ofs_q <= {haddr[7:2], 2'b00};
                wr_be_q <= lane_en(hsize, haddr[1:0]);
                rd_ofs_q <= {haddr[7:2], 2'b00};
            end
            if (take && !hwrite) begin
                rd_pend_q <= 1'b1;
                hreadyout <= 1'b0;
            end else begin
                hreadyout <= 1'b1;
            end
            // read data sampled after any earlier write has landed
            if (rd_pend_q) begin
                case (rd_ofs_q)
                    `MXAF_OFS_E2_HIGH: hrdata <= high_word(ctl_q[0], hi_q[0]);
                    `MXAF_OFS_E2_LOW: hrdata <= lo_q[0];
                    `MXAF_OFS_E3_HIGH: hrdata <= high_word(ctl_q[1], hi_q[1]);
                    `MXAF_OFS_E3_LOW: hrdata <= lo_q[1];
                    `MXAF_OFS_CTRL: hrdata <= {30'h00000000, cfg_q};
                    `MXAF_OFS_STATUS: hrdata <= {29'h00000000, entry_hit,
                        filter_hit};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // register writes in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (k = 0; k < 2; k = k + 1) begin
                ctl_q[k] <= `MXAF_RST_CTL;
                hi_q[k] <= `MXAF_RST_HI;
                lo_q[k] <= `MXAF_RST_LO;
            end
            cfg_q <= `MXAF_RST_CFG;
        end else if (wr_pend_q) begin
            case (wr_ofs_q)
                `MXAF_OFS_E2_HIGH: begin
                    ctl_q[0] <= e2_high_new[`MXAF_HI_ENABLE:`MXAF_HI_MASK_LSB];
                    hi_q[0] <= e2_high_new[`MXAF_HI_ADDR_MSB:0];
                end
                `MXAF_OFS_E2_LOW: lo_q[0] <= merge(lo_q[0], hwdata, wr_be_q);
                `MXAF_OFS_E3_HIGH: begin
                    ctl_q[1] <= e3_high_new[`MXAF_HI_ENABLE:`MXAF_HI_MASK_LSB];
                    hi_q[1] <= e3_high_new[`MXAF_HI_ADDR_MSB:0];
                end
                `MXAF_OFS_E3_LOW: lo_q[1] <= merge(lo_q[1], hwdata, wr_be_q);
                `MXAF_OFS_CTRL: begin
                    if (wr_be_q[0]) begin
                        cfg_q <= hwdata[1:0];
                    end
                end
                default: cfg_q <= cfg_q;
            endcase
        end
    end

    // flag a synced transfer on a write to the trigger lane
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_pend_q <= 2'b00;
        end else begin
            sync_pend_q <= 2'b00;
            if (wr_pend_q && (cfg_q[`MXAF_CTRL_BIGEND] ? wr_be_q[0] :
                wr_be_q[3])) begin
                if (wr_ofs_q == `MXAF_OFS_E2_LOW) begin
                    sync_pend_q[0] <= 1'b1;
                end
                if (wr_ofs_q == `MXAF_OFS_E3_LOW) begin
                    sync_pend_q[1] <= 1'b1;
                end
            end
        end
    end

    // copies used by the filter: follow live unless double-synced
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (k = 0; k < 2; k = k + 1) begin
                act_ctl_q[k] <= `MXAF_RST_CTL;
                act_hi_q[k] <= `MXAF_RST_HI;
                act_lo_q[k] <= `MXAF_RST_LO;
            end
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (!cfg_q[`MXAF_CTRL_DSYNC] || sync_pend_q[k]) begin
                    act_ctl_q[k] <= ctl_q[k];
                    act_hi_q[k] <= hi_q[k];
                    act_lo_q[k] <= lo_q[k];
                end
            end
        end
    end

    // per-entry comparators
    mxaf_entry_match u_match2 (
        .enable(act_ctl_q[0][`MXAF_HI_ENABLE - 24]),
        .use_src(act_ctl_q[0][`MXAF_HI_SRC - 24]),
        .mask(act_ctl_q[0][5:0]),
        .addr({act_hi_q[0], act_lo_q[0]}),
        .frame_dst(frame_dst),
        .frame_src(frame_src),
        .hit(raw_hit[0])
    );

    mxaf_entry_match u_match3 (
        .enable(act_ctl_q[1][`MXAF_HI_ENABLE - 24]),
        .use_src(act_ctl_q[1][`MXAF_HI_SRC - 24]),
        .mask(act_ctl_q[1][5:0]),
        .addr({act_hi_q[1], act_lo_q[1]}),
        .frame_dst(frame_dst),
        .frame_src(frame_src),
        .hit(raw_hit[1])
    );

    // registered verdict for each received frame
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filter_hit_valid <= 1'b0;
            filter_hit <= 1'b0;
            entry_hit <= 2'b00;
        end else begin
            filter_hit_valid <= frame_valid;
            if (frame_valid) begin
                entry_hit <= raw_hit;
                filter_hit <= |raw_hit;
            end
        end
    end
endmodule // mxaf_addr_filter
`default_nettype wire

// ==== mxaf_map.vh ====
// address map, field layout and reset values of the extra address filter
`ifndef MXAF_MAP_VH
`define MXAF_MAP_VH

// register byte offsets (low byte of haddr)
`define MXAF_OFS_E2_HIGH 8'h00
`define MXAF_OFS_E2_LOW 8'h04
`define MXAF_OFS_E3_HIGH 8'h08
`define MXAF_OFS_E3_LOW 8'h0C
`define MXAF_OFS_CTRL 8'h10
`define MXAF_OFS_STATUS 8'h14

// high register fields
`define MXAF_HI_ENABLE 31
`define MXAF_HI_SRC 30
`define MXAF_HI_MASK_MSB 29
`define MXAF_HI_MASK_LSB 24
`define MXAF_HI_ADDR_MSB 15

// control register fields
`define MXAF_CTRL_DSYNC 0
`define MXAF_CTRL_BIGEND 1

// status register fields
`define MXAF_STAT_HIT 0
`define MXAF_STAT_E2 1
`define MXAF_STAT_E3 2

// reset values
`define MXAF_RST_CTL 8'h00
`define MXAF_RST_HI 16'hFFFF
`define MXAF_RST_LO 32'hFFFFFFFF
`define MXAF_RST_CFG 2'h0

// ahb encodings
`define MXAF_HTRANS_NONSEQ 2'h2
`define MXAF_HTRANS_SEQ 2'h3
`define MXAF_HSIZE_BYTE 3'h0
`define MXAF_HSIZE_HALF 3'h1

`endif

// ==== mxaf_entry_match.v ====
// one extra perfect-filter entry compared against a received frame
`timescale 1ns/1ns
`default_nettype none
module mxaf_entry_match (
    input wire enable,
    input wire use_src,
    input wire [5:0] mask,
    input wire [47:0] addr,
    input wire [47:0] frame_dst,
    input wire [47:0] frame_src,
    output reg hit
);
    reg [47:0] field;
    reg all_eq;
    integer i;

    // unmasked bytes must all agree; mask bit i covers addr byte i
    always @* begin
        field = use_src ? frame_src : frame_dst;
        all_eq = 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            if (!mask[i] && (field[i*8 +: 8] != addr[i*8 +: 8])) begin
                all_eq = 1'b0;
            end
        end
        hit = enable & all_eq;
    end
endmodule // mxaf_entry_match
`default_nettype wire

// ==== mxaf_addr_filter_assertions.sv ====
// port checker for the extra address filter
`timescale 1ns/1ns
`default_nettype none
module mxaf_addr_filter_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire frame_valid,
    input wire [47:0] frame_dst,
    input wire [47:0] frame_src,
    input wire filter_hit_valid,
    input wire filter_hit,
    input wire [1:0] entry_hit
);
    // transfers taken on the bus
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    wire wr_take = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    result_follows_a: assert property (frame_valid |=> filter_hit_valid)
        else $error("no result one cycle after frame");
    result_cause_a: assert property (filter_hit_valid |-> $past(frame_valid))
        else $error("result without a frame");
    hit_is_or_a: assert property (filter_hit_valid |-> filter_hit == |entry_hit)
        else $error("hit differs from entry hits");
    levels_hold_a: assert property (!frame_valid |=>
        $stable(entry_hit) && $stable(filter_hit))
        else $error("hit levels moved without frame");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read not one wait cycle");
    write_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write inserted a wait");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_take, 2))
        else $error("read data moved without read");
endmodule // mxaf_addr_filter_chk
bind mxaf_addr_filter mxaf_addr_filter_chk i_chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_valid(frame_valid), .frame_dst(frame_dst),
    .frame_src(frame_src), .filter_hit_valid(filter_hit_valid),
    .filter_hit(filter_hit), .entry_hit(entry_hit));
`default_nettype wire

// ==== mxaf_frame_src.sv ====
// received-frame source standing in for the receive path
`timescale 1ns/1ns
`default_nettype none
module mxaf_frame_src (
    input wire hclk,
    output logic frame_valid,
    output logic [47:0] frame_dst,
    output logic [47:0] frame_src
);
    // idle with no pulse
    initial begin
        frame_valid = 1'b0;
        frame_dst = 48'h0;
        frame_src = 48'h0;
    end
    // one-cycle frame, then fields scrambled so stale values never match
    task send(input logic [47:0] d, input logic [47:0] s);
        @(posedge hclk);
        frame_valid <= 1'b1;
        frame_dst <= d;
        frame_src <= s;
        @(posedge hclk);
        frame_valid <= 1'b0;
        frame_dst <= ~d;
        frame_src <= ~s;
    endtask
endmodule // mxaf_frame_src
`default_nettype wire

// ==== tb_mxaf_addr_filter.sv ====
// self-checking bench for the extra address filter
`timescale 1ns/1ns
`default_nettype none
module tb_mxaf_addr_filter;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, frame_valid, filter_hit_valid, filter_hit;
    wire [1:0] entry_hit;
    wire [47:0] frame_dst, frame_src;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 hclk = ~hclk;
    mxaf_frame_src i_src (.hclk(hclk), .frame_valid(frame_valid),
        .frame_dst(frame_dst), .frame_src(frame_src));
    mxaf_addr_filter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .frame_valid(frame_valid),
        .frame_dst(frame_dst), .frame_src(frame_src),
        .filter_hit_valid(filter_hit_valid), .filter_hit(filter_hit),
        .entry_hit(entry_hit));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // single transfer: address phase, then data phase until ready
    task ahb(input logic w, input logic [7:0] a, input logic [2:0] sz,
        input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, 3'h2, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 3'h2, 32'h0);
        chk(rd, e);
    endtask
    // one frame and its filter result
    task frm(input logic [47:0] d, input logic [47:0] s, input logic [1:0] e);
        i_src.send(d, s);
        #1;
        chk({31'h0, filter_hit_valid}, 32'h1);
        chk({30'h0, entry_hit}, {30'h0, e});
        chk({31'h0, filter_hit}, {31'h0, |e});
    endtask
    task t_reset;
        rdc(8'h00, 32'h0000FFFF);
        rdc(8'h04, 32'hFFFFFFFF);
        rdc(8'h08, 32'h0000FFFF);
        rdc(8'h0C, 32'hFFFFFFFF);
        rdc(8'h20, 32'h0);
        frm(48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFFF, 2'b00);
    endtask
    task t_field;
        wr(8'h04, 32'h33445566);
        wr(8'h00, 32'h80001122);
        rdc(8'h00, 32'h80001122);
        frm(48'h112233445566, 48'h0, 2'b01);
        frm(48'h0, 48'h112233445566, 2'b00);
        wr(8'h00, 32'hC0001122);
        frm(48'h0, 48'h112233445566, 2'b01);
        frm(48'h112233445566, 48'h0, 2'b00);
        wr(8'h00, 32'h00001122);
        frm(48'h112233445566, 48'h112233445566, 2'b00);
    endtask
    task t_mask;
        int i;
        logic [47:0] x;
        wr(8'h0C, 32'hA1B2C3D4);
        for (i = 0; i < 6; i++) begin
            x = 48'hE5F6A1B2C3D4 ^ (48'hFF << (8 * i));
            wr(8'h08, {2'b10, 6'h1 << i, 8'h0, 16'hE5F6});
            frm(x, 48'h0, 2'b10);
            wr(8'h08, {2'b10, 6'h1 << ((i + 1) % 6), 8'h0, 16'hE5F6});
            frm(x, 48'h0, 2'b00);
        end
    endtask
    task t_dsync;
        wr(8'h00, 32'hC0001122);
        frm(48'hE5F6A1B2C300, 48'h112233445566, 2'b11);
        wr(8'h10, 32'h1);
        rdc(8'h10, 32'h1);
        wr(8'h00, 32'h8000AAAA);
        frm(48'h0, 48'h112233445566, 2'b01);
        ahb(1'b1, 8'h04, 3'h0, 32'h00000066);
        frm(48'h0, 48'h112233445566, 2'b01);
        ahb(1'b1, 8'h07, 3'h0, 32'h33000000);
        frm(48'hAAAA33445566, 48'h0, 2'b01);
        wr(8'h10, 32'h3);
        wr(8'h00, 32'h80001122);
        ahb(1'b1, 8'h07, 3'h0, 32'h33000000);
        frm(48'hAAAA33445566, 48'h0, 2'b01);
        ahb(1'b1, 8'h04, 3'h0, 32'h00000066);
        frm(48'h112233445566, 48'h0, 2'b01);
        rdc(8'h14, 32'h00000003);
    endtask
    task wrap_up;
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            wrap_up;
        end
    end
    // reset, then the scenarios
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_field;
        t_mask;
        t_dsync;
        wrap_up;
    end
endmodule // tb_mxaf_addr_filter
`default_nettype wire
